// file: design/fcs_flash_sequencer.v
// flash command sequencer with AHB-Lite register slave
//
// Design decisions made here: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`include "fcs_flash_sequencer_regs.vh"
// Summary of operation
// - divider must set 150-200 kHz; else refuse
// - divider register accepts only one write
// - divider write ignored while access error set
// - pulses timed in whole flash clock periods
// - byte 9, page 4000, mass 20000 cycles
// - chained burst byte in the same row takes 4 cycles, else 9
// - array write latches address and data first
// - erase ignores data; page erase whole page
// - two 60K pages partly hidden by overlaps
// - second step writes one valid command code
// - writing one to buffer-empty launches command
// - writing zero to buffer-empty aborts, errors
// - out-of-order sequences are rejected
// - complete flag sets when a command finishes with none queued or launched
// - access error cleared by writing one
// - unknown command code sets access error
module fcs_flash_sequencer
#(
  parameter        AW          = 16,
  parameter        DIVW        = 10,
  parameter [14:0] PAGE_CYCLES = `FCS_PAGE_CYC,
  parameter [14:0] MASS_CYCLES = `FCS_MASS_CYC
)
(
  // clock and reset
  input  wire          mclk,
  input  wire          rst_n,
  // ahb-lite slave
  input  wire          hsel,
  input  wire [31:0]   haddr,
  input  wire [1:0]    htrans,
  input  wire          hwrite,
  input  wire [2:0]    hsize,
  input  wire [31:0]   hwdata,
  input  wire          hready,
  output wire          hreadyout,
  output wire          hresp,
  output reg  [31:0]   hrdata,
  // interrupt
  output wire          irq,
  // flash array interface
  output reg           hvOn,
  output reg           opStart,
  output reg  [7:0]    opCmd,
  output reg  [AW-1:0] opAddr,
  output reg  [7:0]    opData
);

  // ----------------------------------------
  // constants
  // ----------------------------------------
  // slowest legal divisor rounds down, fastest rounds up
  localparam integer    DIV_MIN_I =
    (`FCS_MCLK_KHZ + `FCS_FLASH_TIMING_CLOCK_MAX_KHZ - 1) / `FCS_FLASH_TIMING_CLOCK_MAX_KHZ;
  localparam integer    DIV_MAX_I = `FCS_MCLK_KHZ / `FCS_FLASH_TIMING_CLOCK_MIN_KHZ;
  localparam [DIVW-1:0] DIV_MIN   = DIV_MIN_I[DIVW-1:0];
  localparam [DIVW-1:0] DIV_MAX   = DIV_MAX_I[DIVW-1:0];
  localparam [14:0] BYTE_CYC  = `FCS_BYTE_CYC;
  localparam [14:0] BURST_CYC = `FCS_BURST_CYC;
  localparam [14:0] BLANK_CYC = `FCS_BLANK_CYC;
  localparam [1:0]  ST_IDLE   = 2'h0;
  localparam [1:0]  ST_ARRAY  = 2'h1;
  localparam [1:0]  ST_CMD    = 2'h2;

  // ----------------------------------------
  // bus address phase capture
  // ----------------------------------------
  reg          dWr;
  reg          dArr;
  reg  [AW-1:0] dAddr;
  reg  [7:0]   dOfs;
  wire accept = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg  [DIVW-1:0] divVal;
  reg             divDone;
  reg             divOk;
  reg             accErr;
  reg             cbef;
  reg             ccf;
  reg  [1:0]      step;
  reg  [AW-1:0]   bufAddr;
  reg  [7:0]      bufData;
  reg  [7:0]      bufCmd;
  reg             pend;
  reg             busy;
  reg             lastBurst;
  reg  [DIVW-1:0] divCnt;
  reg  [14:0]     nCyc;
  reg  [14:0]     target;
  reg  [1:0]      irqStat;
  reg  [1:0]      irqMask;

  // ----------------------------------------
  // write decode (data phase)
  // ----------------------------------------
  wire wArr  = dWr & dArr;
  wire wDiv  = dWr & ~dArr & (dOfs == `FCS_DIV_OFS);
  wire wStat = dWr & ~dArr & (dOfs == `FCS_STAT_OFS);
  wire wCmd  = dWr & ~dArr & (dOfs == `FCS_CMD_OFS);
  wire wIrqm = dWr & ~dArr & (dOfs == `FCS_IRQM_OFS);
  wire wCbef = hwdata[`FCS_CBEF_BIT];
  wire wAcc  = hwdata[`FCS_ACCERR_BIT];
  wire [7:0] wCode = hwdata[7:0];
  wire codeOk = (wCode == `FCS_CMD_BLANK) |
                (wCode == `FCS_CMD_BYTE)  |
                (wCode == `FCS_CMD_BURST) |
                (wCode == `FCS_CMD_PAGE)  |
                (wCode == `FCS_CMD_MASS);
  // every protocol break, only while no error is pending
  wire errArr  = wArr & (~divOk | ~cbef | (step != ST_IDLE));
  wire errCmd  = wCmd & ((step != ST_ARRAY) | ~codeOk);
  wire errDiv  = wDiv & (step != ST_IDLE);
  wire errLnch = wStat & wCbef & (step == ST_ARRAY);
  wire errAbrt = wStat & ~wCbef & (step != ST_IDLE);
  wire errNow  = ~accErr &
                 (errArr | errCmd | errDiv | errLnch | errAbrt);
  wire launch  = ~accErr & wStat & wCbef & (step == ST_CMD);

  // ----------------------------------------
  // flash timing clock
  // ----------------------------------------
  wire divLast = (divCnt == divVal - {{(DIVW-1){1'b0}}, 1'b1});
  wire fTick   = busy & divLast;
  wire lastCyc = fTick & (nCyc == target - 15'h0001);
  wire finish  = busy & lastCyc;
  // burst pacing only when chained in the same row
  wire sameRow = (bufAddr[AW-1:`FCS_ROW_BITS] ==
                  opAddr[AW-1:`FCS_ROW_BITS]);
  wire chain   = lastBurst & (bufCmd == `FCS_CMD_BURST) & sameRow;
  // start of a buffered command, direct or queued; a launch on the
  // finish edge starts at once, else it would wait for a finish never due
  wire startNow = (launch & ~pend & (~busy | finish)) | (finish & pend);
  wire doneNow  = finish & ~pend & ~launch;

  reg  [14:0] next_target;
  reg  [AW-1:0] next_addr;
  always @*
  begin
    next_addr = bufAddr;
    case (bufCmd)
      `FCS_CMD_BYTE:  next_target = BYTE_CYC;
      `FCS_CMD_BURST: next_target = (chain & finish) ? BURST_CYC
                                                     : BYTE_CYC;
      `FCS_CMD_PAGE:
      begin
        next_target = PAGE_CYCLES;
        // pages hidden under ram or high registers keep fewer bytes;
        // the erase still spans the aligned page base
        next_addr = {bufAddr[AW-1:`FCS_PAGE_BITS],
                     {`FCS_PAGE_BITS{1'b0}}};
      end
      `FCS_CMD_MASS:  next_target = MASS_CYCLES;
      default:        next_target = BLANK_CYC;
    endcase
  end

  // ----------------------------------------
  // bus capture and read data
  // ----------------------------------------
  reg [31:0] next_rdata;
  wire [7:0] aOfs = haddr[7:0];
  always @*
  begin
    next_rdata = 32'h0000_0000;
    if (~haddr[`FCS_ARRAY_BIT])
    begin
      case (aOfs)
        `FCS_DIV_OFS:
          next_rdata = {{(31-DIVW){1'b0}}, divDone, divVal};
        `FCS_STAT_OFS:
          next_rdata = {24'h00_0000, cbef, ccf, 1'b0, accErr, 4'h0};
        `FCS_CMD_OFS:   next_rdata = {24'h00_0000, bufCmd};
        `FCS_LADDR_OFS: next_rdata = {{(32-AW){1'b0}}, bufAddr};
        `FCS_LDATA_OFS: next_rdata = {24'h00_0000, bufData};
        `FCS_IRQS_OFS:  next_rdata = {30'h0000_0000, irqStat};
        `FCS_IRQM_OFS:  next_rdata = {30'h0000_0000, irqMask};
        default:        next_rdata = 32'h0000_0000;
      endcase
    end
  end
  // read of the interrupt status clears it
  wire rdIrqs = accept & ~hwrite & ~haddr[`FCS_ARRAY_BIT] &
                (aOfs == `FCS_IRQS_OFS);
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      dWr    <= 1'b0;
      dArr   <= 1'b0;
      dAddr  <= {AW{1'b0}};
      dOfs   <= 8'h00;
      hrdata <= 32'h0000_0000;
    end
    else
    begin
      dWr    <= accept & hwrite;
      dArr   <= haddr[`FCS_ARRAY_BIT];
      dAddr  <= haddr[AW-1:0];
      dOfs   <= aOfs;
      if (accept & ~hwrite)
        hrdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // divider, one write only
  // ----------------------------------------
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      divVal  <= `FCS_DIV_RST;
      divDone <= 1'b0;
      divOk   <= 1'b0;
    end
    else if (wDiv & ~divDone & ~accErr & ~errDiv)
    begin
      divVal  <= hwdata[DIVW-1:0];
      divDone <= 1'b1;
      // out-of-band values leave commands refused until reset
      divOk   <= (hwdata[DIVW-1:0] >= DIV_MIN) &
                 (hwdata[DIVW-1:0] <= DIV_MAX);
    end
  end

  // ----------------------------------------
  // command sequence and flags
  // ----------------------------------------
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      accErr  <= 1'b0;
      cbef    <= 1'b1;
      ccf     <= 1'b1;
      step    <= ST_IDLE;
      bufAddr <= {AW{1'b0}};
      bufData <= 8'h00;
      bufCmd  <= 8'h00;
      pend    <= 1'b0;
    end
    else
    begin
      // error set wins over a same-cycle clear
      if (errNow)
        accErr <= 1'b1;
      else if (wStat & wAcc)
        accErr <= 1'b0;
      if (errNow)
        step <= ST_IDLE;
      else if (~accErr)
      begin
        if (wArr)
        begin
          bufAddr <= dAddr;
          bufData <= hwdata[7:0];
          step    <= ST_ARRAY;
        end
        if (wCmd)
        begin
          bufCmd <= wCode;
          step   <= ST_CMD;
        end
        if (launch)
          step <= ST_IDLE;
      end
      if (launch)
      begin
        cbef <= 1'b0;
        ccf  <= 1'b0;
        pend <= busy & ~finish;
      end
      else if (finish & pend)
        pend <= 1'b0;
      // buffer frees as soon as exec takes it over
      if (startNow)
        cbef <= 1'b1;
      if (doneNow)
        ccf <= 1'b1;
    end
  end

  // ----------------------------------------
  // execution timer
  // ----------------------------------------
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      busy      <= 1'b0;
      hvOn      <= 1'b0;
      opStart   <= 1'b0;
      opCmd     <= 8'h00;
      opAddr    <= {AW{1'b0}};
      opData    <= 8'h00;
      lastBurst <= 1'b0;
      divCnt    <= {DIVW{1'b0}};
      nCyc      <= 15'h0000;
      target    <= 15'h0000;
    end
    else
    begin
      opStart <= startNow;
      if (startNow)
      begin
        busy      <= 1'b1;
        hvOn      <= 1'b1;
        opCmd     <= bufCmd;
        opAddr    <= next_addr;
        // data does not matter to erase or blank check
        opData    <= ((bufCmd == `FCS_CMD_BYTE) |
                      (bufCmd == `FCS_CMD_BURST)) ? bufData
                                                   : 8'hFF;
        lastBurst <= (bufCmd == `FCS_CMD_BURST);
        target    <= next_target;
        divCnt    <= {DIVW{1'b0}};
        nCyc      <= 15'h0000;
      end
      else if (finish)
      begin
        busy      <= 1'b0;
        hvOn      <= 1'b0;
        lastBurst <= 1'b0;
      end
      else if (busy)
      begin
        divCnt <= divLast ? {DIVW{1'b0}}
                          : divCnt + {{(DIVW-1){1'b0}}, 1'b1};
        if (fTick)
          nCyc <= nCyc + 15'h0001;
      end
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  wire [1:0] irqEv = {errNow, doneNow};
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      irqStat <= 2'h0;
      irqMask <= `FCS_IRQM_RST;
    end
    else
    begin
      // a new event beats the clear-on-read
      irqStat <= (rdIrqs ? 2'h0 : irqStat) | irqEv;
      if (wIrqm)
        irqMask <= hwdata[1:0];
    end
  end
  assign irq = |(irqStat & irqMask);
endmodule

// file: design/fcs_flash_sequencer_regs.vh
// register offsets, field positions, reset values and timing counts
`ifndef FCS_FLASH_SEQUENCER_REGS_VH
`define FCS_FLASH_SEQUENCER_REGS_VH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define FCS_DIV_OFS    8'h00
`define FCS_STAT_OFS   8'h04
`define FCS_CMD_OFS    8'h08
`define FCS_LADDR_OFS  8'h0C
`define FCS_LDATA_OFS  8'h10
`define FCS_IRQS_OFS   8'h14
`define FCS_IRQM_OFS   8'h18
// haddr bit that selects the flash array window
`define FCS_ARRAY_BIT  16

// ----------------------------------------
// status fields
// ----------------------------------------
`define FCS_CBEF_BIT   7
`define FCS_CCF_BIT    6
`define FCS_ACCERR_BIT 4
// interrupt status / mask fields
`define FCS_IRQ_DONE   0
`define FCS_IRQ_ERR    1

// ----------------------------------------
// reset values
// ----------------------------------------
`define FCS_DIV_RST    10'h000
`define FCS_IRQM_RST   2'h0

// ----------------------------------------
// command codes
// ----------------------------------------
`define FCS_CMD_BLANK  8'h05
`define FCS_CMD_BYTE   8'h20
`define FCS_CMD_BURST  8'h25
`define FCS_CMD_PAGE   8'h40
`define FCS_CMD_MASS   8'h41

// ----------------------------------------
// timing
// ----------------------------------------
`define FCS_MCLK_KHZ   100000
`define FCS_FLASH_TIMING_CLOCK_MIN_KHZ 150
`define FCS_FLASH_TIMING_CLOCK_MAX_KHZ 200
`define FCS_BYTE_CYC   15'h0009
`define FCS_BURST_CYC  15'h0004
`define FCS_PAGE_CYC   15'h0FA0
`define FCS_MASS_CYC   15'h4E20
`define FCS_BLANK_CYC  15'h0009
`define FCS_PAGE_BITS  9
`define FCS_ROW_BITS   6

`endif

// file: test/fcs_flash_sequencer_props.sv
// port assertions for the flash command sequencer
`timescale 1ns/1ps
module fcs_flash_sequencer_props
#(
  parameter AW = 16
)
(
  // clock and reset
  input wire          mclk,
  input wire          rst_n,
  // flash array side
  input wire          hvOn,
  input wire          opStart,
  input wire [7:0]    opCmd,
  input wire [AW-1:0] opAddr,
  input wire [7:0]    opData
);
  // length of the current high-voltage run, in bus cycles
  logic [31:0] run;
  always @(posedge mclk)
    if (!rst_n || !hvOn)
      run <= 32'h0;
    else
      run <= run + 32'h1;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  start_pulse_a: assert property (opStart |=> !opStart)
    else $error("start pulse longer than one cycle");
  start_hv_a: assert property (opStart |-> hvOn)
    else $error("start without high voltage");
  hv_rise_a: assert property ($rose(hvOn) |-> opStart)
    else $error("high voltage without a start");
  // nine ticks at the fastest legal divider is the shortest run
  hv_len_a: assert property ($fell(hvOn) |-> run >= 32'd4500)
    else $error("high voltage run too short");
  erase_data_a: assert property (opStart && opCmd inside {8'h05, 8'h40, 8'h41}
    |-> opData == 8'hFF) else $error("erase data not ignored");
  page_align_a: assert property (opStart && opCmd == 8'h40
    |-> opAddr[8:0] == 9'h0) else $error("page erase address not aligned");
  code_ok_a: assert property (opStart
    |-> opCmd inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41}) else $error("bad code started");
  op_hold_a: assert property (hvOn && $past(hvOn) && !opStart
    |-> $stable({opCmd, opAddr, opData})) else $error("latched operation changed");
  burst_c: cover property (opStart && opCmd == 8'h25);
  mass_c: cover property (opStart && opCmd == 8'h41);
  done_c: cover property ($fell(hvOn));
endmodule

bind fcs_flash_sequencer fcs_flash_sequencer_props #(.AW(AW)) u_fcs_flash_sequencer_props
(
  .mclk, .rst_n, .hvOn, .opStart, .opCmd, .opAddr, .opData
);

// file: test/fcs_flash_sequencer_tb.sv
// self-checking bench for the flash command sequencer
`timescale 1ns/1ps
`include "fcs_flash_sequencer_regs.vh"
module fcs_flash_sequencer_tb;
  localparam int    DIV = 500;
  localparam [31:0] DV  = `FCS_DIV_OFS;
  localparam [31:0] ST  = `FCS_STAT_OFS;
  localparam [31:0] CM  = `FCS_CMD_OFS;
  localparam [31:0] IS  = `FCS_IRQS_OFS;
  localparam [31:0] IM  = `FCS_IRQM_OFS;
  logic        mclk   = 1'b0;
  logic        rst_n  = 1'b0;
  logic        hsel   = 1'b0;
  logic [31:0] haddr  = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire         hready, hresp, irq, hvOn, opStart;
  wire [31:0]  hrdata;
  wire [7:0]   opCmd, opData;
  wire [15:0]  opAddr;
  logic [31:0] r;
  logic [7:0]  c, d, t, ed;
  logic [15:0] a, ea;
  int          fails = 0;
  int          cmpCount = 0;
  time         t0;
  // code, array address, data, ticks, launched address, launched data
  logic [63:0] rows [5] = '{
    {8'h20, 16'h1234, 8'h5A, 8'h09, 16'h1234, 8'h5A},
    {8'h25, 16'h0040, 8'hA5, 8'h09, 16'h0040, 8'hA5},
    {8'h05, 16'h0321, 8'h77, 8'h09, 16'h0321, 8'hFF},
    {8'h40, 16'h03FF, 8'h11, 8'h14, 16'h0200, 8'hFF},
    {8'h41, 16'h8001, 8'h22, 8'h28, 16'h8001, 8'hFF}};

  // short erase counts keep the run brief; ticks in the rows match them
  fcs_flash_sequencer #(.PAGE_CYCLES(15'd20), .MASS_CYCLES(15'd40)) u_fcs_flash_sequencer
  (
    .mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
    .hreadyout(hready), .hresp, .hrdata, .irq, .hvOn, .opStart, .opCmd, .opAddr, .opData
  );

  initial
  begin
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task rst;
    begin
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
    end
  endtask

  task xf(input w, input [31:0] ad, input [31:0] dt);
    begin
      @(posedge mclk);
      hsel   <= 1'b1;
      haddr  <= ad;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge mclk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= dt;
      do @(posedge mclk); while (hready !== 1'b1);
      r = hrdata;
    end
  endtask

  task chk(input [63:0] g, input [63:0] e);
    begin
      cmpCount++;
      if (g !== e)
      begin
        fails++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask

  task rc(input [31:0] ad, input [31:0] e);
    begin
      xf(1'b0, ad, 32'h0);
      chk(r, e);
      chk(hresp, 1'b0);
    end
  endtask

  task cmd(input [7:0] cc, input [15:0] aa, input [7:0] dd);
    begin
      xf(1'b1, {16'h1, aa}, {24'h0, dd});
      xf(1'b1, CM, {24'h0, cc});
      xf(1'b1, ST, 32'h80);
    end
  endtask

  // wait out the high-voltage run, bounded by the watchdog; returns 1 ns
  // after the edge that drops it
  task wt;
    begin
      do
      begin
        @(posedge mclk);
        #1;
      end
      while (hvOn === 1'b1);
    end
  endtask

  task results;
    begin
      $display("comparisons %0d mismatches %0d", cmpCount, fails);
      if (fails == 0 && cmpCount > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    rst();
    xf(1'b1, DV, DIV);
    xf(1'b1, IM, 32'h1);
    for (int i = 0; i < 5; i++)
    begin
      {c, a, d, t, ea, ed} = rows[i];
      cmd(c, a, d);
      #1;
      t0 = $time;
      chk({opStart, hvOn, opCmd, opAddr, opData}, {2'h3, c, ea, ed});
      wt();
      chk(($time - t0) / 10, t * DIV);
      rc(ST, 32'hC0);
      chk(irq, 1'b1);
      rc(IS, 32'h1);
      #1;
      chk(irq, 1'b0);
      $display("row %0d done", i);
    end
    rst();
    rc(ST, 32'hC0);
    rc(DV, 32'h0);
    rc(IM, 32'h0);
    rc(32'h1C, 32'h0);
    xf(1'b1, IM, 32'h3);
    xf(1'b1, 32'h10000, 32'h0);
    rc(ST, 32'hD0);
    chk(irq, 1'b1);
    xf(1'b1, DV, DIV);
    rc(DV, 32'h0);
    xf(1'b1, ST, 32'h10);
    rc(ST, 32'hC0);
    xf(1'b1, DV, DIV);
    xf(1'b1, DV, 32'd666);
    rc(DV, 32'h5F4);
    rc(IS, 32'h2);
    xf(1'b1, 32'h10005, 32'h5);
    xf(1'b1, ST, 32'h0);
    rc(ST, 32'hD0);
    xf(1'b1, ST, 32'h10);
    xf(1'b1, 32'h10006, 32'h6);
    xf(1'b1, CM, 32'h33);
    rc(ST, 32'hD0);
    xf(1'b1, ST, 32'h10);
    xf(1'b1, CM, 32'h20);
    rc(ST, 32'hD0);
    cmd(8'h20, 16'h0007, 8'h07);
    repeat (4) @(posedge mclk);
    chk(hvOn, 1'b0);
    xf(1'b1, ST, 32'h10);
    $display("reset and refusal tests done");
    cmd(8'h25, 16'h0100, 8'h01);
    #1;
    t0 = $time;
    cmd(8'h25, 16'h0101, 8'h02);
    rc(ST, 32'h0);
    wt();
    chk(($time - t0) / 10, 13 * DIV);
    rc(`FCS_LADDR_OFS, 32'h101);
    rc(`FCS_LDATA_OFS, 32'h2);
    $display("burst chain test done");
    results();
  end

  // the tests need about 50000 cycles; the limit leaves 60 percent more
  initial
  begin
    #800000;
    fails++;
    $display("watchdog expired");
    results();
  end
endmodule
